// ### pkg/eac_pkg.sv
// Constants and types shared by the EEPROM access control block.
// Assumes a core I/O register port and a single 250 MHz clock.
package eac_pkg;

  localparam int EAC_IO_AW = 6;
  localparam int EAC_DW = 8;
  localparam int EAC_AW = 9;
  localparam int EAC_DEPTH = 512;

  // I/O addresses of the access registers.
  localparam logic [EAC_IO_AW-1:0] EAC_OFS_CONTROL = 6'h1C;
  localparam logic [EAC_IO_AW-1:0] EAC_OFS_DATA = 6'h1D;
  localparam logic [EAC_IO_AW-1:0] EAC_OFS_ADDR_LOW = 6'h1E;
  localparam logic [EAC_IO_AW-1:0] EAC_OFS_ADDR_HIGH = 6'h1F;

  // Control register bit positions.
  localparam int EAC_BIT_READ = 0;
  localparam int EAC_BIT_WRITE = 1;
  localparam int EAC_BIT_ARM = 2;
  localparam int EAC_BIT_IRQ_EN = 3;

  localparam logic [EAC_DW-1:0] EAC_RESET_BYTE = 8'h00;
  localparam logic [3:0] EAC_RESERVED_BITS = 4'h0;
  localparam logic [6:0] EAC_ADDR_HIGH_PAD = 7'h00;

  // Timing.
  localparam int EAC_CLK_PERIOD_PS = 4000;
  localparam int EAC_OSC_PERIOD_PS = 1000000;
  localparam int EAC_WRITE_OSC_CYCLES = 8448;
  localparam int EAC_WRITE_CYCLES =
    (EAC_WRITE_OSC_CYCLES * (EAC_OSC_PERIOD_PS / EAC_CLK_PERIOD_PS));
  localparam logic [2:0] EAC_ARM_CYCLES = 3'h4;
  localparam logic [2:0] EAC_WRITE_STALL = 3'h2;
  localparam logic [2:0] EAC_READ_STALL = 3'h4;

  typedef enum logic {
    EAC_IDLE,
    EAC_PROG
  } eac_wstate_t;

endpackage : eac_pkg

// ### src/eac_array.sv
// Byte-wide storage array standing in for the EEPROM cells.
// Assumes one clock; read data appear one edge after rd_en.
`timescale 1ns/1ns
module eac_array #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  input wire logic clk, // Clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic wr_en, // Write one byte.
  input wire logic [AW-1:0] wr_addr, // Write address.
  input wire logic [WIDTH-1:0] wr_data, // Write data.
  input wire logic rd_en, // Read one byte.
  input wire logic [AW-1:0] rd_addr, // Read address.
  output logic [WIDTH-1:0] rd_data_q // Registered read data.
);

  logic [WIDTH-1:0] cells [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_q <= '0;
    end else if (rd_en) begin
      rd_data_q <= cells[rd_addr];
    end
  end

endmodule : eac_array

// ### src/eac_top.sv
// EEPROM access control: control, address and data registers on the core
// I/O port, arm timeout, self-timed write, read path and CPU stall.
// Assumes the core drives one I/O access per cycle, synchronous to clk.
`timescale 1ns/1ns
module eac_top
  import eac_pkg::*;
#(
  parameter int WRITE_CYCLES = eac_pkg::EAC_WRITE_CYCLES
) (
  input wire logic clk, // 250 MHz core clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic [eac_pkg::EAC_IO_AW-1:0] io_addr, // I/O register address.
  input wire logic io_wr, // I/O write strobe.
  input wire logic io_rd, // I/O read strobe.
  input wire logic [eac_pkg::EAC_DW-1:0] io_wdata, // I/O write data.
  output logic [eac_pkg::EAC_DW-1:0] io_rdata_q, // I/O read data.
  input wire logic global_irq_enable, // Interrupt flag of the status word.
  input wire logic self_program_busy, // Flash self-programming running.
  input wire logic powerdown_req, // Core asks for power-down sleep.
  output logic ready_irq_q, // EEPROM ready interrupt request.
  output logic cpu_stall_q, // Halts the core while high.
  output logic osc_run_q, // Timing oscillator kept running.
  output logic powerdown_ok_q, // Power-down may be entered fully.
  output logic write_busy_q // Self-timed write in progress.
);

  localparam int CW = $clog2(WRITE_CYCLES + 1);
  localparam logic [CW-1:0] WRITE_LOAD = CW'(WRITE_CYCLES - 1);

  function automatic logic io_hit(input logic [EAC_IO_AW-1:0] a,
                                  input logic [EAC_IO_AW-1:0] target);
    io_hit = (a == target);
  endfunction : io_hit

  logic wr_ctrl;
  logic wr_data_reg;
  logic wr_addr_low;
  logic wr_addr_high;
  logic start_write;
  logic start_read;
  logic [EAC_DW-1:0] ctrl_view;

  logic irq_en_q;
  logic arm_q;
  logic [2:0] arm_cnt_q;
  eac_wstate_t wstate_q;
  logic [CW-1:0] wcnt_q;
  logic [EAC_AW-1:0] addr_q;
  logic [EAC_DW-1:0] data_q;
  logic [EAC_AW-1:0] prog_addr_q;
  logic [EAC_DW-1:0] prog_data_q;
  logic commit;
  logic read_pend_q;
  logic [2:0] stall_cnt_q;
  logic [2:0] stall_cnt_d;
  logic [EAC_DW-1:0] mem_rdata;
  logic busy;

  assign busy = (wstate_q == EAC_PROG);
  // The array takes the byte on the edge that clears busy, so a read right after sees it.
  assign commit = busy && (wcnt_q == '0);
  assign wr_ctrl = io_wr && io_hit(io_addr, EAC_OFS_CONTROL);
  assign wr_data_reg = io_wr && io_hit(io_addr, EAC_OFS_DATA);
  assign wr_addr_low = io_wr && io_hit(io_addr, EAC_OFS_ADDR_LOW) && !busy;
  assign wr_addr_high = io_wr && io_hit(io_addr, EAC_OFS_ADDR_HIGH) && !busy;

  // A write starts only when armed, idle and flash programming is quiet.
  assign start_write = wr_ctrl && io_wdata[EAC_BIT_WRITE] && arm_q
                       && !busy && !self_program_busy;
  // Reads are refused while a write runs.
  assign start_read = wr_ctrl && io_wdata[EAC_BIT_READ] && !busy
                      && !start_write;

  // Reserved bits read zero; the read strobe completes at once.
  assign ctrl_view = {EAC_RESERVED_BITS, irq_en_q, arm_q, busy, 1'b0};

  // Ready interrupt enable.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en_q <= 1'b0;
    end else if (wr_ctrl) begin
      irq_en_q <= io_wdata[EAC_BIT_IRQ_EN];
    end
  end

  // Arm bit with its self-clearing timeout.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      arm_q <= 1'b0;
      arm_cnt_q <= '0;
    end else if (wr_ctrl && io_wdata[EAC_BIT_ARM]) begin
      arm_q <= 1'b1;
      arm_cnt_q <= EAC_ARM_CYCLES - 3'h1;
    end else if (start_write) begin
      arm_q <= 1'b0;
      arm_cnt_q <= '0;
    end else if (arm_q) begin
      if (arm_cnt_q == '0) begin
        arm_q <= 1'b0;
      end else begin
        arm_cnt_q <= arm_cnt_q - 3'h1;
      end
    end
  end

  // Self-timed programming; power-down does not stop it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wstate_q <= EAC_IDLE;
      wcnt_q <= '0;
    end else begin
      case (wstate_q)
        EAC_IDLE: begin
          if (start_write) begin
            wstate_q <= EAC_PROG;
            wcnt_q <= WRITE_LOAD;
          end
        end
        EAC_PROG: begin
          if (wcnt_q == '0) begin
            wstate_q <= EAC_IDLE;
          end else begin
            wcnt_q <= wcnt_q - CW'(1);
          end
        end
        default: begin
          wstate_q <= EAC_IDLE;
        end
      endcase
    end
  end

  // The byte and location are captured so the data register stays free.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_addr_q <= '0;
      prog_data_q <= EAC_RESET_BYTE;
    end else if (start_write) begin
      prog_addr_q <= addr_q;
      prog_data_q <= data_q;
    end
  end

  // Address register; locked during a write.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_q <= '0;
    end else if (wr_addr_low) begin
      addr_q[EAC_DW-1:0] <= io_wdata;
    end else if (wr_addr_high) begin
      addr_q[EAC_AW-1] <= io_wdata[0];
    end
  end

  // Data register: loaded by software or by a completed read.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_q <= EAC_RESET_BYTE;
      read_pend_q <= 1'b0;
    end else begin
      read_pend_q <= start_read;
      if (read_pend_q) begin
        data_q <= mem_rdata;
      end else if (wr_data_reg) begin
        data_q <= io_wdata;
      end
    end
  end

  // Stall counter covers the array read latency.
  always_comb begin
    stall_cnt_d = stall_cnt_q;
    if (start_read) begin
      stall_cnt_d = EAC_READ_STALL;
    end else if (start_write) begin
      stall_cnt_d = EAC_WRITE_STALL;
    end else if (stall_cnt_q != '0) begin
      stall_cnt_d = stall_cnt_q - 3'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stall_cnt_q <= '0;
      cpu_stall_q <= 1'b0;
    end else begin
      stall_cnt_q <= stall_cnt_d;
      cpu_stall_q <= (stall_cnt_d != '0);
    end
  end

  // I/O read data.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      io_rdata_q <= EAC_RESET_BYTE;
    end else if (io_rd) begin
      if (io_hit(io_addr, EAC_OFS_CONTROL)) begin
        io_rdata_q <= ctrl_view;
      end else if (io_hit(io_addr, EAC_OFS_DATA)) begin
        io_rdata_q <= data_q;
      end else if (io_hit(io_addr, EAC_OFS_ADDR_LOW)) begin
        io_rdata_q <= addr_q[EAC_DW-1:0];
      end else if (io_hit(io_addr, EAC_OFS_ADDR_HIGH)) begin
        io_rdata_q <= {EAC_ADDR_HIGH_PAD, addr_q[EAC_AW-1]};
      end else begin
        io_rdata_q <= EAC_RESET_BYTE;
      end
    end
  end

  // Status outputs; the ready request is a level, not a pulse.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_irq_q <= 1'b0;
      osc_run_q <= 1'b0;
      powerdown_ok_q <= 1'b0;
      write_busy_q <= 1'b0;
    end else begin
      ready_irq_q <= irq_en_q && global_irq_enable && !busy;
      osc_run_q <= busy;
      powerdown_ok_q <= powerdown_req && !busy;
      write_busy_q <= busy;
    end
  end

  eac_array #(
    .WIDTH(EAC_DW),
    .DEPTH(EAC_DEPTH),
    .AW(EAC_AW)
  ) u_array (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(commit),
    .wr_addr(prog_addr_q),
    .wr_data(prog_data_q),
    .rd_en(start_read),
    .rd_addr(addr_q),
    .rd_data_q(mem_rdata)
  );

endmodule : eac_top

// ### tb/eac_top_sva.sv
// Checker on the eac_top ports.
// Assumes the bind below passes the write time used by the design.
`timescale 1ns/1ns
module eac_top_sva #(
  parameter int WRITE_CYCLES = 40
) (
  input wire logic clk, // Clock.
  input wire logic sys_rst, // Reset.
  input wire logic global_irq_enable, // Interrupt flag.
  input wire logic ready_irq_q, // Ready request.
  input wire logic cpu_stall_q, // Core halt.
  input wire logic osc_run_q, // Oscillator kept on.
  input wire logic powerdown_ok_q, // Full sleep allowed.
  input wire logic write_busy_q // Write running.
);
  int busy_cnt_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= write_busy_q ? busy_cnt_q + 1 : 0;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  AST_IRQ_GATE: assert property (!$past(global_irq_enable) |-> !ready_irq_q)
    else $error("ready request without global enable");
  AST_IRQ_BUSY: assert property (write_busy_q |-> !ready_irq_q)
    else $error("ready request during write");
  AST_WRITE_LEN: assert property ($fell(write_busy_q) |-> busy_cnt_q == WRITE_CYCLES)
    else $error("write time wrong");
  AST_WRITE_STALL: assert property ($rose(write_busy_q) |-> cpu_stall_q ##1 !cpu_stall_q)
    else $error("write halt not two cycles");
  AST_READ_STALL: assert property ($rose(cpu_stall_q) ##1 !write_busy_q |->
    cpu_stall_q [*3] ##1 !cpu_stall_q)
    else $error("read halt not four cycles");
  AST_NO_ACCESS_BUSY: assert property (write_busy_q |-> !$rose(cpu_stall_q))
    else $error("access taken during write");
  AST_PD_BLOCK: assert property (powerdown_ok_q |-> !write_busy_q)
    else $error("sleep allowed during write");
  AST_OSC_RUN: assert property (write_busy_q && $past(write_busy_q) |-> osc_run_q)
    else $error("oscillator stopped during write");
  COV_WRITE: cover property ($fell(write_busy_q));
  COV_READ: cover property ($rose(cpu_stall_q) ##1 !write_busy_q);
  COV_SLEEP: cover property ($rose(powerdown_ok_q));
endmodule : eac_top_sva

bind eac_top eac_top_sva #(.WRITE_CYCLES(WRITE_CYCLES)) eac_top_sva_i (
  .clk(clk),
  .sys_rst(sys_rst),
  .global_irq_enable(global_irq_enable),
  .ready_irq_q(ready_irq_q),
  .cpu_stall_q(cpu_stall_q),
  .osc_run_q(osc_run_q),
  .powerdown_ok_q(powerdown_ok_q),
  .write_busy_q(write_busy_q)
);

// ### tb/eac_core_model.sv
// Core model issuing one I/O register access at a time.
// Assumes eac_top takes an access at the rising edge it is high.
`timescale 1ns/1ns
module eac_core_model (
  input wire logic clk, // Clock.
  input wire logic cpu_stall_q, // Core halt.
  input wire logic [eac_pkg::EAC_DW-1:0] io_rdata_q, // Read data.
  output logic [eac_pkg::EAC_IO_AW-1:0] io_addr, // Address.
  output logic io_wr, // Write request.
  output logic io_rd, // Read request.
  output logic [eac_pkg::EAC_DW-1:0] io_wdata // Write data.
);
  import eac_pkg::*;
  initial begin
    io_addr = 6'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // A halted core issues nothing; an idle bus shows inverted values.
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clk);
    while (cpu_stall_q) @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = w;
    io_rd = !w;
    @(negedge clk);
    q = io_rdata_q;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask : acc
endmodule : eac_core_model

// ### tb/test_eac_top.sv
// Testbench for eac_top driven through the core model.
// Assumes a 4 ns clock and a shortened write time.
`timescale 1ns/1ns
module test_eac_top;
  import eac_pkg::*;
  localparam int WC = 40;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic gie = 1'b0;
  logic spb = 1'b0;
  logic pd = 1'b0;
  logic [EAC_IO_AW-1:0] io_addr;
  logic io_wr, io_rd, ready_irq_q, cpu_stall_q, osc_run_q, powerdown_ok_q, write_busy_q;
  logic [EAC_DW-1:0] io_wdata, io_rdata_q, q;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  eac_top #(.WRITE_CYCLES(WC)) eac_top_i (.clk(clk), .sys_rst(sys_rst), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_q(io_rdata_q),
    .global_irq_enable(gie), .self_program_busy(spb), .powerdown_req(pd),
    .ready_irq_q(ready_irq_q), .cpu_stall_q(cpu_stall_q), .osc_run_q(osc_run_q),
    .powerdown_ok_q(powerdown_ok_q), .write_busy_q(write_busy_q));
  eac_core_model eac_core_model_i (.clk(clk), .cpu_stall_q(cpu_stall_q),
    .io_rdata_q(io_rdata_q), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    eac_core_model_i.acc(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [5:0] a, input string n, input logic [7:0] e);
    eac_core_model_i.acc(1'b0, a, 8'h00, q);
    chk(n, q, e);
  endtask : rd
  task automatic results;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    rd(EAC_OFS_CONTROL, "ctl", 8'h00);
    wr(EAC_OFS_CONTROL, 8'hF8);
    rd(EAC_OFS_CONTROL, "ctl", 8'h08);
    chk("irq", {7'h00, ready_irq_q}, 8'h00);
    wr(EAC_OFS_ADDR_HIGH, 8'hFF);
    rd(EAC_OFS_ADDR_HIGH, "ahi", 8'h01);
    wr(EAC_OFS_ADDR_LOW, 8'h34);
    wr(EAC_OFS_DATA, 8'hA5);
    wr(EAC_OFS_CONTROL, 8'h0A);
    rd(EAC_OFS_CONTROL, "unarmed", 8'h08);
    wr(EAC_OFS_CONTROL, 8'h0C);
    rd(EAC_OFS_CONTROL, "arm", 8'h0C);
    repeat (3) @(negedge clk);
    rd(EAC_OFS_CONTROL, "arm", 8'h08);
    wr(EAC_OFS_CONTROL, 8'h0A);
    rd(EAC_OFS_CONTROL, "late", 8'h08);
    spb = 1'b1;
    wr(EAC_OFS_CONTROL, 8'h0C);
    wr(EAC_OFS_CONTROL, 8'h0A);
    rd(EAC_OFS_CONTROL, "flash", 8'h0C);
    chk("wbusy", {7'h00, write_busy_q}, 8'h00);
    repeat (4) @(negedge clk);
    spb = 1'b0;
    pd = 1'b1;
    wr(EAC_OFS_CONTROL, 8'h0C);
    wr(EAC_OFS_CONTROL, 8'h0A);
    gie = 1'b1;
    rd(EAC_OFS_CONTROL, "busy", 8'h0A);
    chk("wbusy", {7'h00, write_busy_q}, 8'h01);
    chk("irq", {7'h00, ready_irq_q}, 8'h00);
    chk("osc", {7'h00, osc_run_q}, 8'h01);
    chk("pdok", {7'h00, powerdown_ok_q}, 8'h00);
    wr(EAC_OFS_ADDR_LOW, 8'h00);
    wr(EAC_OFS_DATA, 8'h5A);
    wr(EAC_OFS_CONTROL, 8'h09);
    wr(EAC_OFS_CONTROL, 8'h0C);
    wr(EAC_OFS_CONTROL, 8'h0A);
    wait (!write_busy_q);
    repeat (2) @(negedge clk);
    chk("irq", {7'h00, ready_irq_q}, 8'h01);
    chk("pdok", {7'h00, powerdown_ok_q}, 8'h01);
    pd = 1'b0;
    gie = 1'b0;
    rd(EAC_OFS_ADDR_LOW, "alo", 8'h34);
    wr(EAC_OFS_CONTROL, 8'h09);
    rd(EAC_OFS_DATA, "data", 8'hA5);
    results();
  end
endmodule : test_eac_top
